// >>> hw/csc_top.sv
// Purpose: charge phase sequencing, rail mode control and AHB-Lite registers
// Assumes: analog loops and comparators live outside; hclk 10 MHz
// Notes: outputs steer analog switches and current/voltage references
//
// The AHB-Lite interface to the registers and the register addresses were decided locally.
`timescale 1ns/10ps

// How it works
// - charging starts only with valid input; inhibit bit and ts pin then decide
// - inhibit set, ts in window, input valid: battery switch off except in supplement or mode 01
// - supplement of the rail ignores the inhibit bit
// - input gone, battery above lockout: rail moves to battery seamlessly
// - below short threshold: trickle at short-battery current
// - trickle and precharge share one quarter-size safety budget
// - precharge current between thresholds, fast current above low threshold
// - termination disabled: precharge current is a fifth of fast current
// - current tapers to termination in cv: charge done flag set
// - regulation voltage code clamped at 4.65 V
// - after termination battery switch off, rail fed from valid input
// - termination only under cv, never with droop, sharing or thermal loops
// - after done, battery at recharge threshold restarts cycle and timers
// - two select bits choose droop threshold, one code disables it
// - droop active sets status flag and blocks termination
// - doubling bit slows safety timer while droop is active
// - rail below share threshold cuts current; sharing blocks termination
// - headroom disable allows low headroom except in tracking mode
// - supplement enters at first margin, leaves at second, blocks termination
// - supplement only with battery above lockout
// - modes 00 and 01 supply rail; pulldown off in both
// - mode 10 floats rail, mode 11 pulls it down
// - input removal and return reverts rail mode to 00
// - battery-only mode during charging stops charging
module csc_top
	import csc_pkg::*;
#(
	parameter int unsigned MS_PER_MINUTE = MS_PER_MIN
) (
	input  wire logic              hclk,
	input  wire logic              hresetn,
	input  wire logic              hsel,
	input  wire logic [7:0]        haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output logic                   hreadyout,
	output logic                   hresp,
	output logic [31:0]            hrdata,
	input  csc_pkg::csc_cmp_t      cmp_in,
	input  wire logic              thermistor_button_pin,
	output csc_pkg::csc_drive_t    drive,
	output logic                   input_droop_active_flag,
	output logic [1:0]             input_droop_select
);
	import csc_pkg::*;

	csc_cmp_t   cmp;
	csc_phase_t phase;
	csc_phase_t next_phase;
	logic [31:0] ctrl;
	logic [7:0]  fast_charge_current;
	logic [7:0]  precharge_current;
	logic [9:0]  battery_regulation_voltage;
	logic [9:0]  safety_minutes;
	logic        charge_done_flag;
	logic        timer_fault_flag;
	logic        supplement;
	logic        in_valid;
	logic        in_valid_q;
	logic        ts_pin_q;
	logic        wr_pend;
	logic [7:0]  wr_addr;
	logic        expired;
	logic        restart;
	logic        can_charge;
	logic        term_ok;
	logic        mode_write;
	logic [16:0] pre_from_fast;
	csc_rail_t   rail_mode_field;

	// the millisecond counter is 18 bits wide; a divider of one would roll it over on every count
	initial begin
		if (MS_PER_MINUTE < 2 || MS_PER_MINUTE > 262_143)
			$error("csc_top: MS_PER_MINUTE out of range");
	end

	csc_sync u_sync (
		.hclk    (hclk),
		.hresetn (hresetn),
		.d       (cmp_in),
		.q       (cmp)
	);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			ts_pin_q <= 1'b0;
		else
			ts_pin_q <= thermistor_button_pin;
	end

	assign in_valid = cmp.in_above_uvlo && cmp.in_above_sleep && cmp.in_below_ovp;

	// ---- AHB-Lite slave: zero wait states, always OKAY
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_addr <= '0;
		end else if (hready) begin
			wr_pend <= hsel && htrans[1] && hwrite && hsize == 3'b010;
			wr_addr <= haddr;
		end
	end

	assign mode_write = wr_pend && wr_addr == ADDR_CTRL;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl <= CTRL_RESET;
		end else begin
			if (mode_write)
				ctrl <= {23'h000000, hwdata[8:0]};
			// adapter dropped: rail mode returns to normal
			if (in_valid_q && !in_valid)
				ctrl[CTRL_MODE_LSB +: 2] <= 2'b00;
			// battery-only asked without a usable battery is refused
			else if (ctrl[CTRL_MODE_LSB +: 2] == 2'b01 && !cmp.bat_above_lockout)
				ctrl[CTRL_MODE_LSB +: 2] <= 2'b00;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fast_charge_current        <= FAST_CHARGE_CURRENT_RESET;
			precharge_current          <= IPRE_RESET;
			battery_regulation_voltage <= VREG_RESET;
			safety_minutes             <= SAFETY_RESET;
		end else if (wr_pend) begin
			unique case (wr_addr)
				ADDR_CURR: begin
					fast_charge_current <= hwdata[7:0];
					precharge_current   <= hwdata[15:8];
				end
				ADDR_VREG:  battery_regulation_voltage <= hwdata[9:0];
				ADDR_TIMER: safety_minutes <= hwdata[9:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			in_valid_q <= 1'b0;
		else
			in_valid_q <= in_valid;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= '0;
		end else if (hready && hsel && htrans[1] && !hwrite) begin
			unique case (haddr)
				ADDR_CTRL:  hrdata <= ctrl;
				ADDR_CURR:  hrdata <= {16'h0000, precharge_current, fast_charge_current};
				ADDR_VREG:  hrdata <= {22'h000000, battery_regulation_voltage};
				ADDR_STAT:  hrdata <= {23'h000000, supplement, cmp.share_active,
					input_droop_active_flag, timer_fault_flag, charge_done_flag,
					1'b0, phase};
				ADDR_TIMER: hrdata <= {22'h000000, safety_minutes};
				default:    hrdata <= '0;
			endcase
		end
	end

	assign rail_mode_field = csc_rail_t'(ctrl[CTRL_MODE_LSB +: 2]);

	// droop select: code 00 disables the droop loop outside
	assign input_droop_select = {ctrl[CTRL_DROOP_HI], ctrl[CTRL_DROOP_LO]};
	assign input_droop_active_flag = cmp.droop_active &&
		(input_droop_select != 2'b00);

	// ---- charge phase machine
	assign can_charge = in_valid && !ctrl[CTRL_INHIBIT] && ts_pin_q && cmp.ts_in_window
		&& rail_mode_field == CSC_RAIL_NORMAL;

	assign term_ok = ctrl[CTRL_TERM_EN] && cmp.cv_active && cmp.at_term_current
		&& !input_droop_active_flag && !cmp.share_active && !cmp.thermal_active
		&& !supplement;

	always_comb begin
		next_phase = phase;
		unique case (phase)
			CSC_IDLE:
				if (can_charge)
					next_phase = !cmp.bat_above_short ? CSC_TRICKLE :
						!cmp.bat_above_lowv ? CSC_PRECHARGE : CSC_FAST;
			CSC_TRICKLE, CSC_PRECHARGE:
				if (!can_charge)
					next_phase = CSC_IDLE;
				else if (expired)
					next_phase = CSC_FAULT;
				else if (cmp.bat_above_lowv)
					next_phase = CSC_FAST;
				else
					next_phase = cmp.bat_above_short ? CSC_PRECHARGE : CSC_TRICKLE;
			CSC_FAST:
				if (!can_charge)
					next_phase = CSC_IDLE;
				else if (term_ok)
					next_phase = CSC_DONE;
				else if (expired)
					next_phase = CSC_FAULT;
			CSC_DONE:
				if (!in_valid)
					next_phase = CSC_IDLE;
				else if (cmp.bat_below_rch && can_charge)
					next_phase = CSC_IDLE;
			CSC_FAULT:
				if (!in_valid)
					next_phase = CSC_IDLE;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			phase <= CSC_IDLE;
		else
			phase <= next_phase;
	end

	// a fresh cycle from idle restarts the safety budget
	assign restart = phase == CSC_IDLE || (phase == CSC_DONE && cmp.bat_below_rch);

	csc_timer #(
		.MS_PER_MINUTE (MS_PER_MINUTE)
	) u_timer (
		.hclk       (hclk),
		.hresetn    (hresetn),
		.restart    (restart),
		.counting   (phase inside {CSC_TRICKLE, CSC_PRECHARGE, CSC_FAST}),
		.pre_phase  (phase inside {CSC_TRICKLE, CSC_PRECHARGE}),
		.slow       (ctrl[CTRL_DBL_EN] && input_droop_active_flag),
		.budget_min (safety_minutes),
		.expired    (expired)
	);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			charge_done_flag <= 1'b0;
			timer_fault_flag <= 1'b0;
		end else begin
			if (phase == CSC_FAST && next_phase == CSC_DONE)
				charge_done_flag <= 1'b1;
			else if (restart && phase != CSC_IDLE)
				charge_done_flag <= 1'b0;
			if (next_phase == CSC_FAULT)
				timer_fault_flag <= 1'b1;
			else if (phase == CSC_IDLE)
				timer_fault_flag <= 1'b0;
		end
	end

	// supplement with hysteresis, independent of inhibit bit
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			supplement <= 1'b0;
		else if (!cmp.bat_above_lockout)
			supplement <= 1'b0;
		else if (cmp.sys_below_enter && rail_mode_field inside {CSC_RAIL_NORMAL})
			supplement <= 1'b1;
		else if (cmp.sys_within_exit)
			supplement <= 1'b0;
	end

	// a fifth of fast current when termination is off: x*13/64 approximates 0.2
	assign pre_from_fast = 17'(fast_charge_current) * 17'd13;

	// ---- drive outputs, all registered
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			drive <= '0;
		end else begin
			drive.charging <= phase inside {CSC_TRICKLE, CSC_PRECHARGE, CSC_FAST};
			// switch on for charge, supplement, or battery feeding the rail
			drive.battery_switch <= (phase inside {CSC_TRICKLE, CSC_PRECHARGE, CSC_FAST})
				|| supplement
				|| ((!in_valid || rail_mode_field == CSC_RAIL_BATT)
					&& cmp.bat_above_lockout
					&& rail_mode_field inside {CSC_RAIL_NORMAL, CSC_RAIL_BATT});
			drive.current_sel <= 2'(phase == CSC_TRICKLE ? 0 :
				phase == CSC_PRECHARGE ? 1 : 2);
			unique case (phase)
				CSC_PRECHARGE: drive.current_code <= ctrl[CTRL_TERM_EN] ?
					precharge_current : pre_from_fast[13:6];
				CSC_FAST:      drive.current_code <= fast_charge_current;
				default:       drive.current_code <= '0;
			endcase
			drive.vreg_code <= battery_regulation_voltage > VREG_MAX ?
				VREG_MAX : battery_regulation_voltage;
			drive.input_switch <= in_valid && rail_mode_field == CSC_RAIL_NORMAL;
			drive.sys_from_batt <= cmp.bat_above_lockout &&
				(rail_mode_field == CSC_RAIL_BATT ||
				(rail_mode_field == CSC_RAIL_NORMAL && !in_valid));
			drive.sys_pulldown <= rail_mode_field == CSC_RAIL_PULLED;
			drive.supplement <= supplement;
			drive.share_headroom_low <= ctrl[CTRL_HEADROOM] && !ctrl[CTRL_TRACK];
		end
	end
endmodule

// >>> pkg/csc_pkg.sv
// Purpose: shared constants and carriers for the charge state controller
// Assumes: 10 MHz hclk, AHB-Lite register access, 32-bit data
// Notes: comparator decisions arrive as one packed struct
package csc_pkg;
	localparam int unsigned CLK_HZ = 10_000_000;
	localparam int unsigned TICK_MS = 1;
	localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
	localparam int unsigned SAFETY_MIN_DEFAULT = 180;
	localparam int unsigned MS_PER_MIN = 60_000;

	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_CURR = 8'h04;
	localparam logic [7:0] ADDR_VREG = 8'h08;
	localparam logic [7:0] ADDR_STAT = 8'h0c;
	localparam logic [7:0] ADDR_TIMER = 8'h10;

	localparam int CTRL_INHIBIT = 0;
	localparam int CTRL_TERM_EN = 1;
	localparam int CTRL_DBL_EN = 2;
	localparam int CTRL_DROOP_LO = 3;
	localparam int CTRL_DROOP_HI = 4;
	localparam int CTRL_HEADROOM = 5;
	localparam int CTRL_MODE_LSB = 6;
	localparam int CTRL_TRACK = 8;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0002;

	localparam logic [7:0] FAST_CHARGE_CURRENT_RESET = 8'h20;
	localparam logic [7:0] IPRE_RESET = 8'h04;
	localparam logic [9:0] VREG_RESET = 10'h1a4;
	localparam logic [9:0] VREG_MAX = 10'h1d1;
	localparam logic [9:0] SAFETY_RESET = 10'h0b4;

	typedef enum logic [1:0] {
		CSC_RAIL_NORMAL,
		CSC_RAIL_BATT,
		CSC_RAIL_FLOAT,
		CSC_RAIL_PULLED
	} csc_rail_t;

	typedef enum logic [2:0] {
		CSC_IDLE,
		CSC_TRICKLE,
		CSC_PRECHARGE,
		CSC_FAST,
		CSC_DONE,
		CSC_FAULT
	} csc_phase_t;

	typedef struct packed {
		logic in_above_uvlo;
		logic in_above_sleep;
		logic in_below_ovp;
		logic ts_in_window;
		logic bat_above_short;
		logic bat_above_lowv;
		logic bat_below_rch;
		logic bat_above_lockout;
		logic at_term_current;
		logic cv_active;
		logic droop_active;
		logic share_active;
		logic thermal_active;
		logic sys_below_enter;
		logic sys_within_exit;
	} csc_cmp_t;

	typedef struct packed {
		logic       battery_switch;
		logic       charging;
		logic [1:0] current_sel;
		logic [7:0] current_code;
		logic [9:0] vreg_code;
		logic       input_switch;
		logic       sys_from_batt;
		logic       sys_pulldown;
		logic       supplement;
		logic       share_headroom_low;
	} csc_drive_t;
endpackage

// >>> hw/csc_sync.sv
// Purpose: two-stage registering of the comparator decision bundle
// Assumes: inputs synchronous to hclk per system setup
// Notes: stage one is read by stage two only
`timescale 1ns/10ps
module csc_sync
	import csc_pkg::*;
(
	input  wire logic     hclk,
	input  wire logic     hresetn,
	input  csc_pkg::csc_cmp_t d,
	output csc_pkg::csc_cmp_t q
);
	csc_cmp_t stage1;

	// comparator noise settles before the phase machine looks at it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stage1 <= '0;
			q      <= '0;
		end else begin
			stage1 <= d;
			q      <= stage1;
		end
	end
endmodule

// >>> hw/csc_timer.sv
// Purpose: safety budget counter for precharge and fast charge
// Assumes: each hclk cycle while counting stands for one millisecond; there is no tick input
// Notes: budget in minutes; precharge budget is a quarter of it
`timescale 1ns/10ps
module csc_timer
	import csc_pkg::*;
#(
	parameter int unsigned MS_PER_MINUTE = MS_PER_MIN
) (
	input  wire logic       hclk,
	input  wire logic       hresetn,
	input  wire logic       restart,
	input  wire logic       counting,
	input  wire logic       pre_phase,
	input  wire logic       slow,
	input  wire logic [9:0] budget_min,
	output logic            expired
);
	logic [17:0] ms_count;
	logic        half;
	logic [9:0]  minutes;
	logic [9:0]  limit;

	initial begin
		if (MS_PER_MINUTE < 2 || MS_PER_MINUTE > 262_143)
			$error("csc_timer: MS_PER_MINUTE out of range");
	end

	// trickle and precharge share one quarter budget
	assign limit = pre_phase ? {2'b00, budget_min[9:2]} : budget_min;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ms_count <= '0;
			half     <= 1'b0;
			minutes  <= '0;
			expired  <= 1'b0;
		end else if (restart) begin
			ms_count <= '0;
			half     <= 1'b0;
			minutes  <= '0;
			expired  <= 1'b0;
		end else if (counting && !expired) begin
			// doubling: count every other millisecond while droop holds
			half <= slow ? ~half : 1'b0;
			if (!slow || half) begin
				if (ms_count == 18'(MS_PER_MINUTE - 1)) begin
					ms_count <= '0;
					minutes  <= minutes + 10'h001;
				end else begin
					ms_count <= ms_count + 18'h00001;
				end
			end
			if (minutes >= limit)
				expired <= 1'b1;
		end
	end
endmodule

// >>> verification/csc_cmp_model.sv
// Purpose: comparator bank standing in for the analog power path
// Assumes: levels in millivolts, thresholds are plain defaults
// Notes: registered so levels move just after a clock edge, never mid-cycle
`timescale 1ns/10ps
module csc_cmp_model
	import csc_pkg::*;
#(
	parameter int UVLO  = 3300,
	parameter int SLEEP = 80,
	parameter int OVP   = 5900,
	parameter int SHORT = 2000,
	parameter int LOWV  = 3000,
	parameter int RCH   = 4000,
	parameter int LOCK  = 2800,
	parameter int SUP1  = 60,
	parameter int SUP2  = 20
) (
	input  wire logic        hclk,
	input  int               vin,
	input  int               vbat,
	input  int               sys_ofs,
	input  wire logic [4:0]  loops,
	output csc_pkg::csc_cmp_t cmp
);
	// rail level given as offset from battery so supplement margins stay exact
	always_ff @(posedge hclk) begin
		cmp <= {vin > UVLO, vin >= vbat + SLEEP, vin < OVP, 1'b1, vbat > SHORT,
			vbat >= LOWV, vbat <= RCH, vbat > LOCK, loops, sys_ofs < -SUP1,
			sys_ofs >= -SUP2};
	end
endmodule

// >>> verification/csc_top_chk.sv
// Purpose: port-level assertions for the charge state controller
// Assumes: comparator levels reach the outputs within five edges
// Notes: windows of eight cycles, four for the droop flag, cover the sync and phase latency
`timescale 1ns/10ps
module csc_top_chk
	import csc_pkg::*;
#(
	parameter int unsigned MS_PER_MINUTE = MS_PER_MIN
) (
	input  wire logic          hclk,
	input  wire logic          hresetn,
	input  csc_pkg::csc_cmp_t   cmp_in,
	input  csc_pkg::csc_drive_t drive,
	input  wire logic          input_droop_active_flag,
	input  wire logic [1:0]    input_droop_select
);
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	AST_OVP_NO_CHG: assert property ((!cmp_in.in_below_ovp)[*8] |-> !drive.charging)
		else $error("charging with input over limit");
	AST_BATT_RAIL: assert property ((!cmp_in.in_above_uvlo && cmp_in.bat_above_lockout)[*8]
		|-> drive.sys_from_batt)
		else $error("rail not on battery");
	AST_TRICKLE_SEL: assert property ((!cmp_in.bat_above_short)[*8] ##0 drive.charging
		|-> drive.current_sel == 2'd0)
		else $error("low battery not trickle");
	AST_FAST_SEL: assert property (cmp_in.bat_above_lowv[*8] ##0 drive.charging
		|-> drive.current_sel == 2'd2)
		else $error("battery above low threshold not fast");
	AST_VREG_CLAMP: assert property (drive.vreg_code <= VREG_MAX)
		else $error("regulation code above clamp");
	AST_DROOP_OFF: assert property (input_droop_select == 2'b00 |-> !input_droop_active_flag)
		else $error("droop flag with droop disabled");
	AST_DROOP_FLAG: assert property ((cmp_in.droop_active && input_droop_select != 2'b00)[*4]
		|-> input_droop_active_flag)
		else $error("droop flag missing");
	AST_SUP_LOCK: assert property ((!cmp_in.bat_above_lockout)[*8] |-> !drive.supplement)
		else $error("supplement below lockout");
	AST_PULL_OFF: assert property (drive.sys_pulldown |-> !drive.input_switch
		&& !drive.sys_from_batt)
		else $error("pulldown with a supply on");
endmodule

bind csc_top csc_top_chk #(.MS_PER_MINUTE(MS_PER_MINUTE)) csc_top_chk_inst (
	.hclk                    (hclk),
	.hresetn                 (hresetn),
	.cmp_in                  (cmp_in),
	.drive                   (drive),
	.input_droop_active_flag (input_droop_active_flag),
	.input_droop_select      (input_droop_select)
);

// >>> verification/csc_top_bench.sv
// Purpose: self-checking bench for the charge state controller
// Assumes: MS_PER_MINUTE of 16 so safety budgets last hundreds of cycles
// Notes: comparator levels come from the model, registers over AHB-Lite
`timescale 1ns/10ps
module csc_top_bench;
	import csc_pkg::*;
	localparam int unsigned MPM = 16;
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, pin, dflag;
	logic [7:0]  haddr;
	logic [1:0]  htrans, dsel;
	logic [2:0]  hsize;
	logic [31:0] hwdata, hrdata, rd;
	logic [4:0]  loops;
	csc_cmp_t    cmp_in;
	csc_drive_t  drive;
	int          vin, vbat, sofs, miscompares, samples_checked, s, d;
	logic [7:0]  ra [5] = '{ADDR_CTRL, ADDR_CURR, ADDR_VREG, ADDR_TIMER, 8'h14};
	logic [31:0] rv [5] = '{32'h2, 32'h420, 32'h1a4, 32'hb4, 32'h0};

	csc_top #(.MS_PER_MINUTE(MPM)) csc_top_inst (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .cmp_in(cmp_in), .thermistor_button_pin(pin), .drive(drive),
		.input_droop_active_flag(dflag), .input_droop_select(dsel));
	csc_cmp_model csc_cmp_model_inst (.hclk(hclk), .vin(vin), .vbat(vbat),
		.sys_ofs(sofs), .loops(loops), .cmp(cmp_in));

	initial begin
		hclk = 0;
		forever #50 hclk = ~hclk;
	end

	task automatic wt(input int n);
		repeat (n) @(posedge hclk);
	endtask

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask

	// waits on hready with no assumed latency; the watchdog bounds a hang
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] v);
		haddr <= a;
		hwrite <= w;
		htrans <= 2'b10;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= v;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
		chk("hresp", 32'h0, hresp);
	endtask

	task automatic st(input logic [2:0] p);
		bus(ADDR_STAT, 1'b0, 32'h0);
		chk("phase", p, rd[2:0]);
	endtask

	task conclude;
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	initial begin
		#(100 * 20000);
		miscompares++;
		conclude;
	end

	initial begin
		hresetn = 0;
		hsel = 1;
		haddr = 0;
		htrans = 0;
		hwrite = 0;
		hsize = 3'b010;
		hwdata = 0;
		pin = 1;
		loops = 0;
		vin = 0;
		vbat = 3700;
		sofs = 200;
		void'($urandom(31985));
		repeat (6) @(posedge hclk);
		hresetn <= 1;
		wt(1);
		foreach (ra[i]) begin
			bus(ra[i], 1'b0, 32'h0);
			chk("reg reset", rv[i], rd);
		end
		bus(8'h14, 1'b1, 32'hffff_ffff);
		bus(8'h14, 1'b0, 32'h0);
		chk("unmapped", 32'h0, rd);
		wt(8);
		chk("rail on battery", 1, drive.sys_from_batt);
		$display("test registers done");

		vin <= 5000;
		vbat <= 1500;
		wt(8);
		st(3'd1);
		chk("sel trickle", 0, drive.current_sel);
		vbat <= 2500;
		wt(8);
		st(3'd2);
		chk("sel pre", 1, drive.current_sel);
		chk("pre code", 4, drive.current_code);
		bus(ADDR_CTRL, 1'b1, 32'h0);
		wt(4);
		chk("pre code no term", 32 * 20 / 100, drive.current_code);
		bus(ADDR_CTRL, 1'b1, 32'h0a);
		bus(ADDR_VREG, 1'b1, 32'h3ff);
		vbat <= 3500;
		wt(8);
		st(3'd3);
		chk("fast code", 32, drive.current_code);
		chk("vreg clamp", 32'h1d1, drive.vreg_code);
		// each limiting loop in turn must hold off termination
		for (int i = 0; i < 3; i++) begin
			loops <= 5'b11000 | (5'b00100 >> i);
			wt(8);
			st(3'd3);
		end
		loops <= 5'b11000;
		vbat <= 4150;
		wt(8);
		bus(ADDR_STAT, 1'b0, 32'h0);
		chk("done", 32'h14, rd[4:0]);
		chk("bat switch", 0, drive.battery_switch);
		chk("in switch", 1, drive.input_switch);
		loops <= 0;
		vbat <= 3900;
		wt(12);
		st(3'd3);
		$display("test charge done");

		bus(ADDR_CTRL, 1'b1, 32'h3);
		wt(8);
		chk("inhibit chg", 0, drive.charging);
		chk("inhibit sw", 0, drive.battery_switch);
		sofs <= -100;
		wt(8);
		chk("sup on", 1, drive.supplement);
		sofs <= -40;
		wt(8);
		chk("sup hold", 1, drive.supplement);
		sofs <= -10;
		wt(8);
		chk("sup off", 0, drive.supplement);
		sofs <= 200;
		$display("test supplement done");

		for (int m = 0; m < 4; m++) begin
			bus(ADDR_CTRL, 1'b1, 32'h2 | (m << 6));
			wt(8);
			chk("pulldown", m == 3, drive.sys_pulldown);
			chk("in switch", m == 0, drive.input_switch);
			if (m == 1) begin
				chk("batt only chg", 0, drive.charging);
			end
		end
		bus(ADDR_CTRL, 1'b1, 32'h22);
		wt(8);
		chk("charging", 1, drive.charging);
		chk("headroom low", 1, drive.share_headroom_low);
		pin <= 1'b0;
		wt(8);
		chk("pin chg", 0, drive.charging);
		pin <= 1'b1;
		vin <= 6500;
		wt(8);
		chk("ovp chg", 0, drive.charging);
		vin <= 5000;
		wt(8);
		bus(ADDR_CTRL, 1'b1, 32'h1e2);
		wt(4);
		chk("headroom track", 0, drive.share_headroom_low);
		vin <= 0;
		wt(8);
		vin <= 5000;
		wt(8);
		bus(ADDR_CTRL, 1'b0, 32'h0);
		chk("mode revert", 0, rd[7:6]);
		$display("test rail done");

		for (int k = 0; k < 16; k++) begin
			s = $urandom_range(3);
			d = $urandom_range(1);
			bus(ADDR_CTRL, 1'b1, 32'h2 | (s << 3));
			loops <= {2'b00, d[0], 2'b00};
			wt(6);
			chk("droop sel", s, dsel);
			chk("droop flag", d != 0 && s != 0, dflag);
		end
		$display("test droop done");

		bus(ADDR_CTRL, 1'b1, 32'h2);
		loops <= 0;
		bus(ADDR_TIMER, 1'b1, 32'h8);
		vin <= 0;
		vbat <= 1500;
		wt(8);
		vin <= 5000;
		wt(16);
		st(3'd1);
		wt(40);
		bus(ADDR_STAT, 1'b0, 32'h0);
		chk("pre budget", 32'h25, rd[5:0]);
		hresetn <= 0;
		wt(2);
		hresetn <= 1;
		wt(1);
		bus(ADDR_TIMER, 1'b0, 32'h0);
		chk("timer reset", 32'hb4, rd);
		$display("test timer done");
		conclude;
	end
endmodule
